// ### logic/hfl_top.sv
// Holdover behaviour control and pull-range bound for the timing loops.
// Assumes a synchronous 8-bit host register port and averager/measure inputs.
`timescale 1ns/1ps
`default_nettype none

module hfl_top (
	// Clock and reset
	input  wire logic                                     i_clk_sys,
	input  wire logic                                     i_reset_n,
	// Host register port
	input  wire logic [7:0]                               i_reg_addr,
	input  wire logic                                     i_reg_wr,
	input  wire logic [7:0]                               i_reg_wdata,
	input  wire logic                                     i_reg_rd,
	output logic      [7:0]                               o_reg_rdata,
	// Primary loop state and frequency sources
	input  wire logic                                     i_holdover,
	input  wire logic                                     i_mini_holdover,
	input  wire logic                                     i_manual_holdover,
	input  wire logic signed [hfl_pkg::HFL_FREQ_W-1:0]    i_inst_freq,
	input  wire logic signed [hfl_pkg::HFL_FREQ_W-1:0]    i_avg_fast,
	input  wire logic signed [hfl_pkg::HFL_FREQ_W-1:0]    i_avg_slow,
	// Loop offsets and oscillator calibration
	input  wire logic signed [hfl_pkg::HFL_OFS_W-1:0]     i_primary_loop_offset,
	input  wire logic signed [hfl_pkg::HFL_OFS_W-1:0]     i_secondary_loop_offset,
	input  wire logic signed [hfl_pkg::HFL_OFS_W-1:0]     i_xo_cal,
	// Loop frequency results
	output logic signed [hfl_pkg::HFL_FREQ_W-1:0]         o_hold_freq,
	output logic signed [hfl_pkg::HFL_OFS_W:0]            o_primary_loop_offset,
	output logic                                          o_primary_loop_at_limit,
	output logic signed [hfl_pkg::HFL_OFS_W:0]            o_secondary_loop_offset,
	output logic                                          o_secondary_loop_at_limit,
	output logic [hfl_pkg::HFL_BOUND_W-1:0]               o_pull_range_bound
);
	import hfl_pkg::*;

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Pick the fast or slow averager output
	function automatic logic signed [HFL_FREQ_W-1:0] pick_avg(
		input logic                         fast,
		input logic signed [HFL_FREQ_W-1:0] f_val,
		input logic signed [HFL_FREQ_W-1:0] s_val
	);
		pick_avg = fast ? f_val : s_val;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] hold_lo_reg;    // Written holdover word bits 7:0
	logic [7:0] hold_mi_reg;    // Written holdover word bits 15:8
	logic [7:0] modes_reg;      // Behaviour control
	logic [7:0] bound_low_reg;  // Bound bits 7:0
	logic [1:0] bound_high_reg; // Bound bits 9:8
	logic [7:0] rdata_reg;      // Read data holding register

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire sel_lo    = (i_reg_addr == HFL_ADDR_HOLD_FREQ_LO);
	wire sel_mi    = (i_reg_addr == HFL_ADDR_HOLD_FREQ_MI);
	wire sel_modes = (i_reg_addr == HFL_ADDR_HOLD_MODES);
	wire sel_blow  = (i_reg_addr == HFL_ADDR_BOUND_LOW);
	wire sel_bhigh = (i_reg_addr == HFL_ADDR_BOUND_HIGH);

	// ----------------------------------------
	// Field views
	// ----------------------------------------
	wire       auto_avg  = modes_reg[HFL_BIT_AUTO_AVG];
	wire       fast_avg  = modes_reg[HFL_BIT_FAST_AVG];
	wire       read_avg  = modes_reg[HFL_BIT_READ_AVG];
	hfl_mini_t mini_mode;
	assign mini_mode = hfl_mini_t'(modes_reg[HFL_BIT_MINI_HI:HFL_BIT_MINI_LO]);

	// Written holdover word, 19 bits joined over three registers
	wire signed [HFL_FREQ_W-1:0] written_freq =
		{modes_reg[HFL_BIT_HFREQ_HI:0], hold_mi_reg, hold_lo_reg};

	// Averaged frequency the quick-filter bit selects
	wire signed [HFL_FREQ_W-1:0] sel_avg = pick_avg(fast_avg, i_avg_fast, i_avg_slow);

	// Value presented on the holdover word readback
	wire signed [HFL_FREQ_W-1:0] read_freq = read_avg ? sel_avg : written_freq;

	// Joined pull-range bound
	wire [HFL_BOUND_W-1:0] pull_range_bound = {bound_high_reg, bound_low_reg};

	// ----------------------------------------
	// Register writes
	// ----------------------------------------

	// Host writes; control register keeps all eight bits
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_lo_reg    <= HFL_RST_HOLD_FREQ_LO;
			hold_mi_reg    <= HFL_RST_HOLD_FREQ_MI;
			modes_reg      <= HFL_RST_HOLD_MODES;
			bound_low_reg  <= HFL_RST_BOUND_LOW;
			bound_high_reg <= HFL_RST_BOUND_HIGH[HFL_BIT_BOUND_HI:0];
		end else if (i_reg_wr) begin
			if (sel_lo) begin
				hold_lo_reg <= i_reg_wdata;
			end else if (sel_mi) begin
				hold_mi_reg <= i_reg_wdata;
			end else if (sel_modes) begin
				modes_reg <= i_reg_wdata;
			end else if (sel_blow) begin
				bound_low_reg <= i_reg_wdata;
			end else if (sel_bhigh) begin
				bound_high_reg <= i_reg_wdata[HFL_BIT_BOUND_HI:0];
			end
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------

	// Read mux; unmapped addresses and unused bits read zero
	logic [7:0] rd_mux;
	assign rd_mux =
		sel_lo    ? read_freq[7:0] :
		sel_mi    ? read_freq[15:8] :
		sel_modes ? {modes_reg[7:HFL_BIT_HFREQ_HI+1], read_freq[HFL_FREQ_W-1:16]} :
		sel_blow  ? bound_low_reg :
		sel_bhigh ? {6'h00, bound_high_reg} :
		8'h00;

	// Read data captured on the read strobe and held
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_reg <= 8'h00;
		end else if (i_reg_rd) begin
			rdata_reg <= rd_mux;
		end
	end
	assign o_reg_rdata = rdata_reg;

	// ----------------------------------------
	// Frozen frequency capture
	// ----------------------------------------
	logic                        hold_any_reg; // Holdover or mini seen last cycle
	logic signed [HFL_FREQ_W-1:0] frozen_reg;   // Frequency at loss of input
	wire                         hold_any   = i_holdover | i_mini_holdover;
	wire                         hold_entry = hold_any & ~hold_any_reg;
	// Frozen value; on the entry cycle itself the current frequency is used,
	// so a stale value from an earlier loss never reaches the output
	wire signed [HFL_FREQ_W-1:0] frozen_val = hold_entry ? i_inst_freq : frozen_reg;

	// Freeze the instantaneous frequency on entry to either holdover
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_any_reg <= 1'b0;
			frozen_reg   <= '0;
		end else begin
			hold_any_reg <= hold_any;
			if (hold_entry) begin
				frozen_reg <= i_inst_freq;
			end
		end
	end

	// ----------------------------------------
	// Holdover frequency selection
	// ----------------------------------------

	// Full holdover: manual wins, then averager, else frozen
	logic signed [HFL_FREQ_W-1:0] full_freq;
	assign full_freq =
		i_manual_holdover ? written_freq :
		auto_avg          ? sel_avg :
		frozen_val;

	// Brief loss: per field code; reserved code acts as full holdover
	logic signed [HFL_FREQ_W-1:0] mini_freq;
	assign mini_freq =
		(mini_mode == HFL_MINI_FREEZE) ? frozen_val :
		(mini_mode == HFL_MINI_FAST)   ? i_avg_fast :
		full_freq;

	// Output word; the frozen value uses the current entry, averaged values pass live
	logic signed [HFL_FREQ_W-1:0] hold_freq_next;
	assign hold_freq_next =
		i_holdover      ? full_freq :
		i_mini_holdover ? mini_freq :
		i_inst_freq;

	// Register the loop frequency output
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_hold_freq <= '0;
		end else begin
			o_hold_freq <= hold_freq_next;
		end
	end

	// ----------------------------------------
	// Pull-range clamps for both loops
	// ----------------------------------------

	// Primary loop clamp
	hfl_clamp u_primary_clamp (
		.i_clk_sys  (i_clk_sys),
		.i_reset_n  (i_reset_n),
		.i_offset   (i_primary_loop_offset),
		.i_xo_cal   (i_xo_cal),
		.i_bound    (pull_range_bound),
		.o_offset   (o_primary_loop_offset),
		.o_at_limit (o_primary_loop_at_limit)
	);

	// Secondary loop clamp
	hfl_clamp u_secondary_clamp (
		.i_clk_sys  (i_clk_sys),
		.i_reset_n  (i_reset_n),
		.i_offset   (i_secondary_loop_offset),
		.i_xo_cal   (i_xo_cal),
		.i_bound    (pull_range_bound),
		.o_offset   (o_secondary_loop_offset),
		.o_at_limit (o_secondary_loop_at_limit)
	);

	// Bound shown to the loops, straight from registers
	assign o_pull_range_bound = pull_range_bound;

endmodule

`default_nettype wire

// ### logic/hfl_pkg.sv
// Package for the holdover mode and pull-range bound block.
// Assumes one system clock and an 8-bit register port from the host.
package hfl_pkg;

	// ----------------------------------------
	// Register offsets on the host port
	// ----------------------------------------
	localparam logic [7:0] HFL_ADDR_HOLD_FREQ_LO = 8'h3E; // Holdover word bits 7:0
	localparam logic [7:0] HFL_ADDR_HOLD_FREQ_MI = 8'h3F; // Holdover word bits 15:8
	localparam logic [7:0] HFL_ADDR_HOLD_MODES   = 8'h40; // Holdover behaviour control
	localparam logic [7:0] HFL_ADDR_BOUND_LOW    = 8'h41; // Pull-range bound bits 7:0
	localparam logic [7:0] HFL_ADDR_BOUND_HIGH   = 8'h42; // Pull-range bound bits 9:8

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [7:0] HFL_RST_HOLD_FREQ_LO = 8'h00;
	localparam logic [7:0] HFL_RST_HOLD_FREQ_MI = 8'h00;
	localparam logic [7:0] HFL_RST_HOLD_MODES   = 8'h88;
	localparam logic [7:0] HFL_RST_BOUND_LOW    = 8'h76;
	localparam logic [7:0] HFL_RST_BOUND_HIGH   = 8'h00;

	// ----------------------------------------
	// Field positions in the behaviour control register
	// ----------------------------------------
	localparam int HFL_BIT_AUTO_AVG  = 7; // Averaged holdover select
	localparam int HFL_BIT_FAST_AVG  = 6; // Quick-filter select
	localparam int HFL_BIT_READ_AVG  = 5; // Filtered-readback select
	localparam int HFL_BIT_MINI_HI   = 4; // Brief-loss field, upper bit
	localparam int HFL_BIT_MINI_LO   = 3; // Brief-loss field, lower bit
	localparam int HFL_BIT_HFREQ_HI  = 2; // Holdover word bit 18 lives here
	localparam int HFL_BIT_BOUND_HI  = 1; // Upper bound register, bit 9

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int HFL_FREQ_W  = 19; // Holdover frequency word
	localparam int HFL_BOUND_W = 10; // Joined pull-range bound
	localparam int HFL_OFS_W   = 12; // Offset input, in bound units

	// ----------------------------------------
	// Brief-loss handling codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		HFL_MINI_RSVD   = 2'h0,
		HFL_MINI_AS_FULL = 2'h1,
		HFL_MINI_FREEZE  = 2'h2,
		HFL_MINI_FAST    = 2'h3
	} hfl_mini_t;

endpackage

// ### logic/hfl_clamp.sv
// Symmetric pull-range clamp for one loop's frequency offset.
// Assumes offset and calibration share the bound's unit and sign convention.
`timescale 1ns/1ps
`default_nettype none

module hfl_clamp (
	// Clock and reset
	input  wire logic                                 i_clk_sys,
	input  wire logic                                 i_reset_n,
	// Offset in, calibration and bound
	input  wire logic signed [hfl_pkg::HFL_OFS_W-1:0] i_offset,
	input  wire logic signed [hfl_pkg::HFL_OFS_W-1:0] i_xo_cal,
	input  wire logic        [hfl_pkg::HFL_BOUND_W-1:0] i_bound,
	// Clamped offset and limit flag
	output logic signed [hfl_pkg::HFL_OFS_W:0]        o_offset,
	output logic                                      o_at_limit
);
	import hfl_pkg::*;

	// ----------------------------------------
	// Combinational clamp
	// ----------------------------------------
	logic signed [HFL_OFS_W:0] sum;       // Offset with calibration folded in
	logic signed [HFL_OFS_W:0] pos_bound; // Upper limit
	logic signed [HFL_OFS_W:0] neg_bound; // Lower limit
	logic                      over_hi;   // Above the upper limit
	logic                      over_lo;   // Below the lower limit
	logic signed [HFL_OFS_W:0] out_next;  // Clamped value

	assign sum       = {i_offset[HFL_OFS_W-1], i_offset} + {i_xo_cal[HFL_OFS_W-1], i_xo_cal};
	assign pos_bound = signed'({{(HFL_OFS_W+1-HFL_BOUND_W){1'b0}}, i_bound});
	assign neg_bound = -pos_bound;
	assign over_hi   = sum > pos_bound;
	assign over_lo   = sum < neg_bound;
	assign out_next  = over_hi ? pos_bound : (over_lo ? neg_bound : sum);

	// Register the clamped offset and flag
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_offset   <= '0;
			o_at_limit <= 1'b0;
		end else begin
			o_offset   <= out_next;
			o_at_limit <= over_hi | over_lo;
		end
	end

endmodule

`default_nettype wire

// ### test/hfl_top_properties.sv
// Port-level checker for the holdover mode and pull-range bound block.
// Assumes one clock domain; shadows control and holdover word registers.
`timescale 1ns/1ps
`default_nettype none
module hfl_top_properties (
	input wire logic               i_clk_sys,
	input wire logic               i_reset_n,
	input wire logic [7:0]         i_reg_addr,
	input wire logic               i_reg_wr,
	input wire logic [7:0]         i_reg_wdata,
	input wire logic               i_reg_rd,
	input wire logic [7:0]         o_reg_rdata,
	input wire logic               i_holdover,
	input wire logic               i_mini_holdover,
	input wire logic               i_manual_holdover,
	input wire logic signed [18:0] i_inst_freq,
	input wire logic signed [18:0] i_avg_fast,
	input wire logic signed [18:0] i_avg_slow,
	input wire logic signed [11:0] i_primary_loop_offset,
	input wire logic signed [11:0] i_xo_cal,
	input wire logic signed [18:0] o_hold_freq,
	input wire logic signed [12:0] o_primary_loop_offset,
	input wire logic               o_primary_loop_at_limit,
	input wire logic [9:0]         o_pull_range_bound
);
	logic        [7:0]  mode_reg;                                  // Shadow control register
	logic        [15:0] word_reg;                                  // Shadow holdover word
	wire logic          fsel     = mode_reg[6];                    // Fast averager chosen
	wire logic          any_loss = i_holdover || i_mini_holdover;  // Either loss state
	wire logic   [18:0] word     = {mode_reg[2:0], word_reg};      // Manual holdover word
	wire logic   [7:0]  rd_avg   = fsel ? i_avg_fast[7:0] : i_avg_slow[7:0];
	wire logic signed [12:0] sum = 13'(i_primary_loop_offset) + 13'(i_xo_cal);
	wire logic signed [12:0] bnd = {3'b000, o_pull_range_bound};
	// Shadow registers follow host writes
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_reg <= 8'h88;
			word_reg <= 16'h0000;
		end else if (i_reg_wr) begin
			if (i_reg_addr == 8'h40) mode_reg <= i_reg_wdata;
			if (i_reg_addr == 8'h3F) word_reg[15:8] <= i_reg_wdata;
			if (i_reg_addr == 8'h3E) word_reg[7:0] <= i_reg_wdata;
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// Entry into holdover with averaging and manual both off
	sequence s_freeze;
		$rose(any_loss) && i_holdover ##1 i_holdover && !i_manual_holdover && !mode_reg[7];
	endsequence
	AST_BOUND_LOW: assert property (i_reg_wr && i_reg_addr == 8'h41 |=>
		o_pull_range_bound[7:0] == $past(i_reg_wdata)) else $error("bound low not written");
	AST_BOUND_HIGH: assert property (i_reg_wr && i_reg_addr == 8'h42 |=>
		{6'h00, o_pull_range_bound[9:8]} == ($past(i_reg_wdata) & 8'h03)) else $error("bound high not joined");
	AST_AVG_USED: assert property (i_holdover && !i_manual_holdover && mode_reg[7] |=>
		o_hold_freq == ($past(fsel) ? $past(i_avg_fast) : $past(i_avg_slow))) else $error("average not used");
	AST_FROZEN: assert property (s_freeze |=> o_hold_freq == $past(i_inst_freq, 2))
		else $error("frozen value not used");
	AST_MANUAL: assert property (i_holdover && i_manual_holdover |=> o_hold_freq == $past(word))
		else $error("manual word not used");
	AST_MINI_FAST: assert property (i_mini_holdover && !i_holdover && mode_reg[4:3] == 2'b11 |=>
		o_hold_freq == $past(i_avg_fast)) else $error("brief loss not fast average");
	AST_CLAMP_HI: assert property (sum > bnd |=> o_primary_loop_at_limit &&
		o_primary_loop_offset == $past(bnd)) else $error("upper clamp wrong");
	AST_CLAMP_LO: assert property (sum < -bnd |=> o_primary_loop_at_limit &&
		o_primary_loop_offset == -$past(bnd)) else $error("lower clamp wrong");
	AST_CLAMP_IN: assert property (sum <= bnd && sum >= -bnd |=> !o_primary_loop_at_limit &&
		o_primary_loop_offset == $past(sum)) else $error("calibrated offset wrong");
	AST_RD_AVG: assert property (i_reg_rd && i_reg_addr == 8'h3E && mode_reg[5] |=>
		o_reg_rdata == $past(rd_avg)) else $error("averaged readback wrong");
endmodule
bind hfl_top hfl_top_properties hfl_top_properties_inst (.*);
`default_nettype wire

// ### test/hfl_host.sv
// Host model: drives the block's register port.
// Assumes requests start 1 ns after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module hfl_host (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_reg_rdata,
	output logic      [7:0] o_reg_addr,
	output logic            o_reg_wr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_rd
);
	initial begin
		o_reg_addr = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_wdata = 8'h00;
		o_reg_rd = 1'b0;
	end
	// One write, strobe held for one taking edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		#1;
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_reg_wr = 1'b0;
		o_reg_wdata = ~d;
	endtask
	// One read, data valid just after the taking edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk_sys);
		#1;
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_reg_rd = 1'b0;
		d = i_reg_rdata;
	endtask
endmodule
`default_nettype wire

// ### test/hfl_top_tb.sv
// Self-checking bench for the holdover mode and pull-range bound block.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module hfl_top_tb;
	logic clk, rst_n, wr, rd, hold, mini, man, mo, opat, osat;
	logic [7:0] addr, wdata, rdata, mode, lo, hi, d;
	logic signed [18:0] inst, fast, slow, ohold, f;
	logic signed [11:0] poff, soff, xo;
	logic signed [12:0] opoff, osoff;
	logic [9:0] bound;
	logic [31:0] seed = 32'h0000_de72;
	int error_cnt = 0;
	int n_compared = 0;
	hfl_top hfl_top_inst (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_holdover(hold), .i_mini_holdover(mini),
		.i_manual_holdover(man), .i_inst_freq(inst), .i_avg_fast(fast), .i_avg_slow(slow),
		.i_primary_loop_offset(poff), .i_secondary_loop_offset(soff), .i_xo_cal(xo), .o_hold_freq(ohold),
		.o_primary_loop_offset(opoff), .o_primary_loop_at_limit(opat), .o_secondary_loop_offset(osoff),
		.o_secondary_loop_at_limit(osat), .o_pull_range_bound(bound));
	hfl_host hfl_host_inst (.i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
		.o_reg_wdata(wdata), .o_reg_rd(rd));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Frequency the loop should use in a loss state
	function logic [18:0] exp_hold(input logic [7:0] m, input logic brief, input logic [18:0] w);
		if (brief && m[4:3] == 2'b11) return fast;
		if (brief && m[4:3] == 2'b10) return f;
		if (man) return w;
		if (m[7]) return m[6] ? fast : slow;
		return f;
	endfunction
	// Symmetric clamp, limit flag on top
	function logic [13:0] exp_clamp(input logic signed [12:0] s, input logic [9:0] b);
		logic signed [12:0] bs;
		bs = {3'b000, b};
		if (s > bs) return {1'b1, bs};
		if (s < -bs) return {1'b1, -bs};
		return {1'b0, s};
	endfunction
	task chk(input logic [18:0] got, input logic [18:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end
	initial begin
		{rst_n, hold, mini, man, inst, fast, slow, poff, soff, xo, f} = '0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(bound, 10'h076);
		hfl_host_inst.rd_reg(8'h40, d);
		chk(d, 8'h88);
		hfl_host_inst.rd_reg(8'h55, d);
		chk(d, 8'h00);
		// Bound join and clamp, zero and full-scale bound first
		for (int i = 0; i < 5; i++) begin
			lo = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(rnd());
			hi = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(rnd());
			hfl_host_inst.wr_reg(8'h41, lo);
			hfl_host_inst.wr_reg(8'h42, hi);
			chk(bound, {hi[1:0], lo});
			hfl_host_inst.rd_reg(8'h42, d);
			chk(d, {6'h00, hi[1:0]});
			repeat (10) begin
				poff = 12'(rnd());
				soff = 12'(rnd());
				xo = 12'(rnd() >> 22);
				@(posedge clk);
				#1;
				chk({opat, opoff}, exp_clamp(poff + xo, bound));
				chk({osat, osoff}, exp_clamp(soff + xo, bound));
			end
		end
		// Holdover and brief-loss modes with readback
		for (int i = 0; i < 32; i++) begin
			mode = 8'(rnd());
			mode[4:3] = i[1:0];
			lo = 8'(rnd());
			hi = 8'(rnd());
			hfl_host_inst.wr_reg(8'h40, mode);
			hfl_host_inst.wr_reg(8'h3E, lo);
			hfl_host_inst.wr_reg(8'h3F, hi);
			{fast, slow, f} = {19'(rnd()), 19'(rnd()), 19'(rnd())};
			inst = f;
			man = 1'(rnd() >> 7);
			mo = i[2];
			hold = !mo;
			mini = mo;
			@(posedge clk);
			#1 inst = 19'(rnd());
			@(posedge clk);
			#1;
			chk(ohold, exp_hold(mode, mo, {mode[2:0], hi, lo}));
			hfl_host_inst.rd_reg(8'h3E, d);
			chk(d, mode[5] ? (mode[6] ? fast[7:0] : slow[7:0]) : lo);
			hfl_host_inst.rd_reg(8'h3F, d);
			chk(d, mode[5] ? (mode[6] ? fast[15:8] : slow[15:8]) : hi);
			hfl_host_inst.rd_reg(8'h40, d);
			chk(d, {mode[7:3], mode[5] ? (mode[6] ? fast[18:16] : slow[18:16]) : mode[2:0]});
			hold = 1'b0;
			mini = 1'b0;
		end
		finish_test();
	end
endmodule
`default_nettype wire
